/* src/asc_consts.svh */
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// register offsets on the 3-bit port
`define ASC_OFF_DATA      3'h0
`define ASC_OFF_IRQ_EN    3'h1
`define ASC_OFF_IRQ_SRC   3'h2
`define ASC_OFF_LINE_FMT  3'h3
`define ASC_OFF_HS_OUT    3'h4
`define ASC_OFF_LINE_ST   3'h5
`define ASC_OFF_HS_IN     3'h6
`define ASC_OFF_SCRATCH   3'h7

// line format fields
`define ASC_LF_LEN_LSB    0
`define ASC_LF_STOP       2
`define ASC_LF_PAR_EN     3
`define ASC_LF_EVEN       4
`define ASC_LF_STICK      5
`define ASC_LF_BREAK      6
`define ASC_LF_DIVISOR_ACCESS_BIT       7

// handshake output fields
`define ASC_HO_DTR        0
`define ASC_HO_RTS        1
`define ASC_HO_OUT1       2
`define ASC_HO_OUT2       3
`define ASC_HO_LOOP       4

// interrupt source codes
`define ASC_ID_LINE       2'h3
`define ASC_ID_RXDATA     2'h2
`define ASC_ID_TXEMPTY    2'h1
`define ASC_ID_MODEM      2'h0

// reset values
`define ASC_RST_BYTE      8'h00
`define ASC_RST_DIVISOR   16'h0001

// timing: system clock and baud reference
`define ASC_CLK_HZ        125000000
`define ASC_REF_HZ        1843200
`define ASC_ACC_W         27
`define ASC_TICKS_BIT     5'h10
`define ASC_TICKS_1P5     5'h18
`define ASC_TICKS_2       6'h20
`define ASC_MID_BIT       4'h7

`endif

/* src/asc_pkg.sv */
package asc_pkg;

  typedef enum logic [2:0] {ASC_TX_IDLE, ASC_TX_START, ASC_TX_DATA, ASC_TX_PAR, ASC_TX_STOP} asc_tx_state_t;
  typedef enum logic [2:0] {ASC_RX_IDLE, ASC_RX_START, ASC_RX_DATA, ASC_RX_PAR, ASC_RX_STOP} asc_rx_state_t;

  // number of data bits minus one for the length select
  function automatic logic [2:0] asc_last_bit(input logic [1:0] len_sel);
    asc_last_bit = {1'b1, len_sel};
  endfunction : asc_last_bit

  // parity bit for a character under the current format
  function automatic logic asc_parity(input logic [7:0] d, input logic [1:0] len_sel,
                                      input logic even, input logic stick);
    logic [7:0] m;
    m = d & (8'hFF >> (3'h3 - {1'b0, len_sel}));
    if (stick) asc_parity = ~even;
    else asc_parity = even ? (^m) : ~(^m);
  endfunction : asc_parity

endpackage : asc_pkg

/* src/asc_buf_if.sv */
`timescale 1ns/1ps
// valid/ready byte channel into and out of the receive buffer
interface asc_buf_if;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] in_data;
  logic       out_valid;
  logic       out_ready;
  logic [7:0] out_data;
  modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : asc_buf_if

/* src/asc_rx_buffer.sv */
`timescale 1ns/1ps
module asc_rx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic  clk,
  input  wire logic  reset_n,
  asc_buf_if.buffer  bus
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push = bus.in_valid & bus.in_ready;
  assign pop  = bus.out_valid & bus.out_ready;
  // full stops the writer honestly; the receiver turns that into overrun
  assign bus.in_ready  = (count != (AW+1)'(DEPTH));
  assign bus.out_valid = (count != '0);
  assign bus.out_data  = mem[rd_ptr];

  // storage is plain registers, head read straight out of them
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= bus.in_data;
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : asc_rx_buffer

/* src/asc_channel.sv */
`timescale 1ns/1ps
`include "asc_consts.svh"

// Function
// - enable bits 0..3 gate rx data, tx empty, line status, modem interrupts
// - id bit 0 reads zero while an enabled interrupt is pending
// - id bits 2:1 name the source, bits 7:3 read zero
// - format bits 1:0 select five to eight data bits
// - format bit 2 selects stop bit count on transmit
// - format bits 3..6 give parity enable, even, stick and break
// - format bit 7 maps offsets 0 and 1 onto the divisor bytes
// - handshake bits drive terminal ready, send request, two outputs, loopback
// - line state bits 0..3 are ready, overrun, parity and framing errors
// - line state bits 4..6 are break, hold empty, shift empty
// - handshake input bits 0..3 record changes since last read
// - handshake input bits 4..7 show present input levels
// - divisor is sixteen bits split into low and high bytes
// - divisor gives sixteen times baud from the reference rate
// - offsets 0..7 map data, enables, id, format, handshake out, status, handshake in, scratch
// - frame is start, data, optional parity, one, 1.5 or two stops
// - divisor 1 to 65535 clocks both transmitter and receiver
module asc_channel
  import asc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output      logic [7:0] reg_rdata,
  output      logic       irq,
  input  wire logic       sin,
  output      logic       sout,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       dcd_n,
  output      logic       dtr_n,
  output      logic       rts_n,
  output      logic       out1_n,
  output      logic       out2_n
);

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0]     irq_enable_reg;
  logic [7:0]     line_format_reg;
  logic [7:0]     handshake_out_reg;
  logic [7:0]     scratch_reg;
  logic [7:0]     divisor_low_byte;
  logic [7:0]     divisor_high_byte;
  logic [7:0]     tx_hold_reg;
  logic           tx_hold_empty;
  logic           tx_shift_empty;
  logic           overrun, parity_error, framing_error, break_seen;
  logic           cts_changed, dsr_changed, ring_trailing_edge, carrier_changed;
  logic           tx_hold_empty_pend;
  logic [3:0]     hs_now, hs_prev;
  logic [7:0]     line_state_reg, handshake_in_reg, irq_source_reg;
  logic [1:0]     irq_code;
  logic           irq_any;
  logic           divisor_access_bit, loop_on, wr_thr, rd_rbr, rd_lsr, rd_msr, rd_iir;
  logic           tx_load;
  asc_buf_if      rxb ();

  assign divisor_access_bit    = line_format_reg[`ASC_LF_DIVISOR_ACCESS_BIT];
  assign loop_on = handshake_out_reg[`ASC_HO_LOOP];

  // offset decode with the divisor access overlay
  assign wr_thr = reg_wr && reg_addr == `ASC_OFF_DATA && !divisor_access_bit;
  assign rd_rbr = reg_rd && reg_addr == `ASC_OFF_DATA && !divisor_access_bit;
  assign rd_lsr = reg_rd && reg_addr == `ASC_OFF_LINE_ST;
  assign rd_msr = reg_rd && reg_addr == `ASC_OFF_HS_IN;
  assign rd_iir = reg_rd && reg_addr == `ASC_OFF_IRQ_SRC;

  // plain read/write registers; unused upper bits are never stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable_reg    <= `ASC_RST_BYTE;
      line_format_reg   <= `ASC_RST_BYTE;
      handshake_out_reg <= `ASC_RST_BYTE;
      scratch_reg       <= `ASC_RST_BYTE;
      divisor_low_byte  <= 8'(`ASC_RST_DIVISOR);
      divisor_high_byte <= 8'(`ASC_RST_DIVISOR >> 8);
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ASC_OFF_DATA:     if (divisor_access_bit) divisor_low_byte <= reg_wdata;
        `ASC_OFF_IRQ_EN: begin
          if (divisor_access_bit) divisor_high_byte <= reg_wdata;
          else irq_enable_reg <= {4'h0, reg_wdata[3:0]};
        end
        `ASC_OFF_LINE_FMT: line_format_reg <= reg_wdata;
        `ASC_OFF_HS_OUT:   handshake_out_reg <= {3'h0, reg_wdata[4:0]};
        `ASC_OFF_SCRATCH:  scratch_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generation: reference enable, then divisor down to 16x tick
  logic [`ASC_ACC_W-1:0] ref_acc;
  logic                  ref_en;
  logic [15:0]           div_cnt;
  logic                  tick;
  logic [15:0]           divisor;

  assign divisor = {divisor_high_byte, divisor_low_byte};

  // fractional accumulator: average rate is exact, jitter is one clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_acc <= '0;
      ref_en  <= 1'b0;
    end else if (ref_acc + `ASC_ACC_W'(`ASC_REF_HZ) >= `ASC_ACC_W'(`ASC_CLK_HZ)) begin
      ref_acc <= ref_acc + `ASC_ACC_W'(`ASC_REF_HZ) - `ASC_ACC_W'(`ASC_CLK_HZ);
      ref_en  <= 1'b1;
    end else begin
      ref_acc <= ref_acc + `ASC_ACC_W'(`ASC_REF_HZ);
      ref_en  <= 1'b0;
    end
  end

  // a zero divisor behaves as 65536 rather than stalling the line
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (ref_en) begin
        if (div_cnt >= divisor - 16'h0001) begin // a lowered divisor must not wait for a wrap
          div_cnt <= '0;
          tick    <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  asc_tx_state_t tx_state;
  logic [5:0]    tx_cnt;
  logic [7:0]    tx_shift;
  logic [2:0]    tx_bit;
  logic          tx_line;
  logic [5:0]    stop_ticks;

  // 1.5 stops only for five-bit characters
  always_comb begin
    if (!line_format_reg[`ASC_LF_STOP]) stop_ticks = {1'b0, `ASC_TICKS_BIT};
    else if (line_format_reg[1:0] == 2'h0) stop_ticks = {1'b0, `ASC_TICKS_1P5};
    else stop_ticks = `ASC_TICKS_2;
  end

  assign tx_load = (tx_state == ASC_TX_IDLE) && !tx_hold_empty;

  // holding register and its empty flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_hold_reg   <= `ASC_RST_BYTE;
      tx_hold_empty <= 1'b1;
    end else if (wr_thr) begin
      tx_hold_reg   <= reg_wdata;
      tx_hold_empty <= 1'b0;
    end else if (tx_load) begin
      tx_hold_empty <= 1'b1;
    end
  end

  // frame sequencer, 16 ticks per bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= ASC_TX_IDLE;
      tx_cnt   <= '0;
      tx_shift <= '0;
      tx_bit   <= '0;
      tx_line  <= 1'b1;
    end else if (tx_load) begin
      tx_state <= ASC_TX_START;
      tx_shift <= tx_hold_reg;
      tx_cnt   <= '0;
      tx_bit   <= '0;
      tx_line  <= 1'b0;
    end else if (tick && tx_state != ASC_TX_IDLE) begin
      tx_cnt <= tx_cnt + 6'h01;
      if (tx_state == ASC_TX_STOP ? tx_cnt == stop_ticks - 6'h01 : tx_cnt == 6'h0F) begin
        tx_cnt <= '0;
        unique case (tx_state)
          ASC_TX_START: begin
            tx_state <= ASC_TX_DATA;
            tx_line  <= tx_shift[0];
          end
          ASC_TX_DATA: begin
            if (tx_bit == asc_last_bit(line_format_reg[1:0])) begin
              if (line_format_reg[`ASC_LF_PAR_EN]) begin
                tx_state <= ASC_TX_PAR;
                tx_line  <= asc_parity(tx_shift, line_format_reg[1:0],
                                       line_format_reg[`ASC_LF_EVEN], line_format_reg[`ASC_LF_STICK]);
              end else begin
                tx_state <= ASC_TX_STOP;
                tx_line  <= 1'b1;
              end
            end else begin
              tx_bit  <= tx_bit + 3'h1;
              tx_line <= tx_shift[tx_bit + 3'h1];
            end
          end
          ASC_TX_PAR: begin
            tx_state <= ASC_TX_STOP;
            tx_line  <= 1'b1;
          end
          ASC_TX_STOP: tx_state <= ASC_TX_IDLE;
          default: tx_state <= ASC_TX_IDLE;
        endcase
      end
    end
  end

  assign tx_shift_empty = (tx_state == ASC_TX_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // receiver: start validated at mid bit, then one sample per 16 ticks
  asc_rx_state_t rx_state;
  logic [3:0]    rx_cnt;
  logic [2:0]    rx_bit;
  logic [7:0]    rx_shift;
  logic          rx_in, rx_par, rx_zero, rx_done, rx_pe, rx_fe, rx_brk;

  assign rx_in = loop_on ? tx_line : sin;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= ASC_RX_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_par   <= 1'b0;
      rx_zero  <= 1'b0;
      rx_done  <= 1'b0;
      rx_pe    <= 1'b0;
      rx_fe    <= 1'b0;
      rx_brk   <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_cnt <= rx_cnt + 4'h1;
        unique case (rx_state)
          ASC_RX_IDLE: begin
            rx_cnt <= '0;
            if (!rx_in) rx_state <= ASC_RX_START;
          end
          ASC_RX_START: if (rx_cnt == `ASC_MID_BIT) begin
            rx_cnt   <= '0;
            rx_bit   <= '0;
            rx_shift <= '0;
            rx_zero  <= 1'b1;
            rx_state <= rx_in ? ASC_RX_IDLE : ASC_RX_DATA; // glitch rejected
          end
          ASC_RX_DATA: if (rx_cnt == 4'hF) begin
            rx_shift[rx_bit] <= rx_in;
            rx_zero <= rx_zero & ~rx_in;
            rx_bit  <= rx_bit + 3'h1;
            if (rx_bit == asc_last_bit(line_format_reg[1:0]))
              rx_state <= line_format_reg[`ASC_LF_PAR_EN] ? ASC_RX_PAR : ASC_RX_STOP;
          end
          ASC_RX_PAR: if (rx_cnt == 4'hF) begin
            rx_par   <= rx_in;
            rx_zero  <= rx_zero & ~rx_in;
            rx_state <= ASC_RX_STOP;
          end
          ASC_RX_STOP: if (rx_cnt == 4'hF) begin
            rx_pe    <= line_format_reg[`ASC_LF_PAR_EN] &&
                        rx_par != asc_parity(rx_shift, line_format_reg[1:0],
                                             line_format_reg[`ASC_LF_EVEN], line_format_reg[`ASC_LF_STICK]);
            rx_fe    <= !rx_in;
            rx_brk   <= rx_zero & ~rx_in;
            rx_done  <= 1'b1;
            rx_state <= ASC_RX_IDLE;
          end
          default: rx_state <= ASC_RX_IDLE;
        endcase
      end
    end
  end

  // two-entry buffer between receiver and read port
  assign rxb.in_valid  = rx_done;
  assign rxb.in_data   = rx_shift;
  assign rxb.out_ready = rd_rbr;
  asc_rx_buffer #(.WIDTH(8), .DEPTH(2)) u_rx_buffer (
    .clk     (clk),
    .reset_n (reset_n),
    .bus     (rxb.buffer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // line status flags: a new event wins over the clearing read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overrun       <= 1'b0;
      parity_error  <= 1'b0;
      framing_error <= 1'b0;
      break_seen    <= 1'b0;
    end else begin
      overrun       <= (overrun & ~rd_lsr) | (rx_done & ~rxb.in_ready);
      parity_error  <= (parity_error & ~rd_lsr) | (rx_done & rx_pe);
      framing_error <= (framing_error & ~rd_lsr) | (rx_done & rx_fe);
      break_seen    <= (break_seen & ~rd_lsr) | (rx_done & rx_brk);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake inputs, looped back from the outputs in loopback mode
  always_comb begin
    if (loop_on) hs_now = {handshake_out_reg[`ASC_HO_OUT2], handshake_out_reg[`ASC_HO_OUT1],
                           handshake_out_reg[`ASC_HO_DTR], handshake_out_reg[`ASC_HO_RTS]};
    else hs_now = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
  end

  // change flags are sticky until the handshake input read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_prev            <= 4'h0;
      cts_changed        <= 1'b0;
      dsr_changed        <= 1'b0;
      ring_trailing_edge <= 1'b0;
      carrier_changed    <= 1'b0;
    end else begin
      hs_prev            <= hs_now;
      cts_changed        <= (cts_changed & ~rd_msr) | (hs_now[0] ^ hs_prev[0]);
      dsr_changed        <= (dsr_changed & ~rd_msr) | (hs_now[1] ^ hs_prev[1]);
      ring_trailing_edge <= (ring_trailing_edge & ~rd_msr) | (~hs_now[2] & hs_prev[2]);
      carrier_changed    <= (carrier_changed & ~rd_msr) | (hs_now[3] ^ hs_prev[3]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt identification
  // tx empty source is cleared by reading its id or refilling the holder
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tx_hold_empty_pend <= 1'b0;
    else if (tx_load && !wr_thr) tx_hold_empty_pend <= 1'b1;
    else if (wr_thr || (rd_iir && irq_code == `ASC_ID_TXEMPTY)) tx_hold_empty_pend <= 1'b0;
  end

  assign line_state_reg   = {1'b0, tx_shift_empty, tx_hold_empty, break_seen,
                             framing_error, parity_error, overrun, rxb.out_valid};
  assign handshake_in_reg = {hs_now[3], hs_now[2], hs_now[1], hs_now[0], carrier_changed,
                             ring_trailing_edge, dsr_changed, cts_changed};

  always_comb begin
    irq_any  = 1'b1;
    irq_code = `ASC_ID_MODEM;
    if (irq_enable_reg[2] && (overrun | parity_error | framing_error | break_seen))
      irq_code = `ASC_ID_LINE;
    else if (irq_enable_reg[0] && rxb.out_valid)
      irq_code = `ASC_ID_RXDATA;
    else if (irq_enable_reg[1] && tx_hold_empty_pend)
      irq_code = `ASC_ID_TXEMPTY;
    else if (!(irq_enable_reg[3] && handshake_in_reg[3:0] != 4'h0))
      irq_any = 1'b0;
  end

  assign irq_source_reg = {5'h00, irq_code, ~irq_any};

  ////////////////////////////////////////////////////////////////////////////
  // read data, pins and interrupt line all leave from flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ASC_OFF_DATA:     reg_rdata <= divisor_access_bit ? divisor_low_byte : rxb.out_data;
        `ASC_OFF_IRQ_EN:   reg_rdata <= divisor_access_bit ? divisor_high_byte : irq_enable_reg;
        `ASC_OFF_IRQ_SRC:  reg_rdata <= irq_source_reg;
        `ASC_OFF_LINE_FMT: reg_rdata <= line_format_reg;
        `ASC_OFF_HS_OUT:   reg_rdata <= handshake_out_reg;
        `ASC_OFF_LINE_ST:  reg_rdata <= line_state_reg;
        `ASC_OFF_HS_IN:    reg_rdata <= handshake_in_reg;
        `ASC_OFF_SCRATCH:  reg_rdata <= scratch_reg;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // loopback parks the pins inactive and keeps the line at mark
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sout   <= 1'b1;
      dtr_n  <= 1'b1;
      rts_n  <= 1'b1;
      out1_n <= 1'b1;
      out2_n <= 1'b1;
      irq    <= 1'b0;
    end else begin
      sout   <= loop_on | (tx_line & ~line_format_reg[`ASC_LF_BREAK]);
      dtr_n  <= loop_on | ~handshake_out_reg[`ASC_HO_DTR];
      rts_n  <= loop_on | ~handshake_out_reg[`ASC_HO_RTS];
      out1_n <= loop_on | ~handshake_out_reg[`ASC_HO_OUT1];
      out2_n <= loop_on | ~handshake_out_reg[`ASC_HO_OUT2];
      irq    <= irq_any;
    end
  end

endmodule : asc_channel

/* tb/asc_serial_peer.sv */
`timescale 1ns/1ps
// remote terminal: sends frames at divisor 1 and keeps its modem lines inactive
module asc_serial_peer (
  input  logic clk,
  output logic sin,
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n
);
  // 16 reference ticks at divisor 1, counted in 125 MHz clocks
  localparam int BIT_CLKS = 1085;

  // line idles high, handshake lines stay released
  initial begin
    sin = 1'b1;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    ri_n = 1'b1;
    dcd_n = 1'b1;
  end

  // stop level is a knob so a framing fault can be sent on purpose
  task automatic send(input logic [7:0] d, input int n, input logic parity_on, input logic pv, input logic sv);
    @(posedge clk);
    sin <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sin <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    if (parity_on) begin
      sin <= pv;
      repeat (BIT_CLKS) @(posedge clk);
    end
    sin <= sv;
    repeat (BIT_CLKS) @(posedge clk);
    sin <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : send
endmodule : asc_serial_peer

/* tb/asc_channel_properties.sv */
`timescale 1ns/1ps
module asc_channel_properties (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       sout,
  input wire logic       dtr_n,
  input wire logic       rts_n,
  input wire logic       out1_n,
  input wire logic       out2_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] hs_w;

  // last byte written to the handshake register, for pin comparison
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) hs_w <= 8'h00;
    else if (reg_wr && reg_addr == 3'h4) hs_w <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////
  property p_id_zero; reg_rd && reg_addr == 3'h2 |=> reg_rdata[7:3] == 5'h00; endproperty
  a_id_zero: assert property (p_id_zero) else $error("id upper bits set");
  property p_id_irq; reg_rd && reg_addr == 3'h2 |=> reg_rdata[0] == !irq; endproperty
  a_id_irq: assert property (p_id_irq) else $error("id bit 0 disagrees with irq");
  property p_hs_zero; reg_rd && reg_addr == 3'h4 |=> reg_rdata[7:5] == 3'h0; endproperty
  a_hs_zero: assert property (p_hs_zero) else $error("handshake upper bits set");
  property p_ls_zero; reg_rd && reg_addr == 3'h5 |=> !reg_rdata[7]; endproperty
  a_ls_zero: assert property (p_ls_zero) else $error("line state bit 7 set");
  property p_scratch;
    reg_wr && reg_addr == 3'h7 ##2 reg_rd && reg_addr == 3'h7 |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");
  property p_outs;
    reg_wr && reg_addr == 3'h4 && !reg_wdata[4] |=> ##1 {dtr_n, rts_n, out1_n, out2_n} == ~{hs_w[0], hs_w[1], hs_w[2], hs_w[3]};
  endproperty
  a_outs: assert property (p_outs) else $error("modem outputs wrong");
  property p_loop_outs; reg_wr && reg_addr == 3'h4 && reg_wdata[4] |=> ##1 {dtr_n, rts_n, out1_n, out2_n} == 4'hF; endproperty
  a_loop_outs: assert property (p_loop_outs) else $error("outputs active in loopback");
  property p_break; reg_wr && reg_addr == 3'h3 && reg_wdata[6] && !dtr_n |=> ##[0:1] !sout; endproperty
  a_break: assert property (p_break) else $error("break not on line");
  c_rx_read: cover property (reg_rd && reg_addr == 3'h0 ##1 reg_rdata != 8'h00);
  c_irq: cover property ($rose(irq));
  c_loop: cover property (reg_wr && reg_addr == 3'h4 && reg_wdata[4]);
endmodule : asc_channel_properties

bind asc_channel asc_channel_properties i_props (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq), .sout(sout),
  .dtr_n(dtr_n), .rts_n(rts_n), .out1_n(out1_n), .out2_n(out2_n));

/* tb/asc_channel_bench.sv */
`timescale 1ns/1ps
module asc_channel_bench;
  import asc_pkg::*;
  logic       clk, reset_n, reg_wr, reg_rd, irq, sin, sout, cts_n, dsr_n, ri_n, dcd_n;
  logic       dtr_n, rts_n, out1_n, out2_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, q;
  wire  [7:0] pins = {4'h0, dtr_n, rts_n, out1_n, out2_n};
  int         n_fail, checks_done;

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  asc_channel i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq), .sin(sin), .sout(sout), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .dtr_n(dtr_n), .rts_n(rts_n), .out1_n(out1_n), .out2_n(out2_n));
  asc_serial_peer i_peer (.clk(clk), .sin(sin), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

  ////////////////////////////////////////////////////////////////
  // one-cycle strobes; data is read once the read edge has landed
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    cmp(v, exp);
  endtask : chk
  task automatic results;
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(3'h1, 8'h00);
    chk(3'h2, 8'h01);
    chk(3'h3, 8'h00);
    chk(3'h5, 8'h60);
    cmp(pins, 8'h0F);
  endtask : t_reset
  task automatic t_regs;
    wr(3'h1, 8'hFF);
    chk(3'h1, 8'h0F);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'hFF);
    chk(3'h2, 8'h01);
    wr(3'h7, 8'h5A);
    chk(3'h7, 8'h5A);
    wr(3'h4, 8'h0F);
    repeat (2) @(posedge clk);
    cmp(pins, 8'h00);
    wr(3'h3, 8'h43);
    repeat (2) @(posedge clk);
    cmp({7'h0, sout}, 8'h00);
    wr(3'h4, 8'hFF);
    chk(3'h4, 8'h1F);
    cmp(pins, 8'h0F);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h0C);
    wr(3'h1, 8'h01);
    chk(3'h0, 8'h0C);
    chk(3'h1, 8'h01);
    chk(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    chk(3'h1, 8'h00);
  endtask : t_regs
  // third byte meets a full two-entry buffer and must be dropped
  task automatic t_rx;
    i_peer.send(8'hA5, 8, 1'b0, 1'b0, 1'b1);
    i_peer.send(8'h3C, 8, 1'b0, 1'b0, 1'b1);
    i_peer.send(8'h5A, 8, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk(3'h5, 8'h63);
    chk(3'h0, 8'hA5);
    chk(3'h0, 8'h3C);
    chk(3'h5, 8'h60);
  endtask : t_rx
  // seven bits, even parity, wrong parity and low stop bit
  task automatic t_err;
    wr(3'h3, 8'h1A);
    i_peer.send(8'h55, 7, 1'b1, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    chk(3'h5, 8'h6D);
    chk(3'h5, 8'h61);
    chk(3'h0, 8'h55);
  endtask : t_err
  task automatic t_loop;
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h01);
    rd(3'h6, q);
    wr(3'h4, 8'h13);
    repeat (4) @(posedge clk);
    chk(3'h6, 8'h33);
    chk(3'h6, 8'h30);
    wr(3'h0, 8'h96);
    for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge clk);
    cmp({7'h0, irq}, 8'h01);
    chk(3'h2, 8'h04);
    chk(3'h0, 8'h96);
    chk(3'h2, 8'h01);
    wr(3'h1, 8'h03);
    chk(3'h2, 8'h02);
    chk(3'h2, 8'h01);
    wr(3'h4, 8'h00);
  endtask : t_loop

  // main sequence, reset held for eight cycles
  initial begin
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_rx();
    t_err();
    t_loop();
    results();
  end
  // watchdog: five frames at divisor 1 take about 60k clocks
  initial begin
    #700000;
    n_fail++;
    results();
  end
endmodule : asc_channel_bench
